// *** src/gate_drive_ctrl.sv ***
`timescale 1ns/1ps
`include "drive_consts.svh"
// ************************************************
// How it works
// - Clamp drive on while gate below threshold and drive off
// - Comparator above threshold flags overcurrent
// - Sense held low unless output high
// - Overcurrent starts two-level off, flags fault
// - Output held low until fault cleared
// - Hold mid level, then soft sink
// - Fault flag low until valid reset
// - Resets ignored during mute interval
// - Enable pulled low, disabled by default
// - Long low enable, release on rise
// - Enable low gives normal turn-off
// - Duty linear, 10% to 88%
// - Floating sense gives 400kHz minimum duty
// - Output high only outside undervoltage
// - Power-good flag low during undervoltage
// - Sense pwm held low in undervoltage
// - Pulses under 40ns rejected
// ************************************************
module gate_drive_ctrl
   import drive_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic pwm_in_p,
   input wire logic pwm_in_n,
   input wire logic rst_en_in,
   input wire logic vcc_uvlo,
   input wire logic vdd_uvlo,
   input wire logic overcurrent_sense,
   input wire logic gate_below_clamp,
   input wire logic gate_at_neg_rail,
   input wire logic [12:0] analog_sense_in,
   output logic gate_out,
   output logic mid_turnoff_level,
   output logic soft_turnoff_current,
   output logic clamp_drive,
   output logic oc_pulldown_o,
   output logic oc_pulldown_oe,
   input wire logic fault_flag_n_i,
   output logic fault_flag_n_o,
   output logic fault_flag_n_oe,
   input wire logic ready_i,
   output logic ready_o,
   output logic ready_oe,
   output logic analog_pwm_out
);
   localparam int HOLD_M1 = `MID_HOLD_CYC - 1;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // ************************************************
   // Pin synchronisers
   // ************************************************
   logic [6:0] sy1_r;
   logic [6:0] sy2_r;
   logic pwm_p_f;
   logic pwm_n_f;
   logic en_f;

   always_ff @(posedge mclk) begin
      if (rst) begin
         sy1_r <= `SYNC_RST;
         sy2_r <= `SYNC_RST;
      end else begin
         sy1_r <= {vcc_uvlo, vdd_uvlo, overcurrent_sense, gate_below_clamp,
            gate_at_neg_rail, fault_flag_n_i, ready_i};
         sy2_r <= sy1_r;
      end
   end

   wire uvlo_s = sy2_r[6] | sy2_r[5];
   wire oc_s = sy2_r[4];
   wire below_s = sy2_r[3];
   wire at_vee_s = sy2_r[2];
   wire flt_pin_s = sy2_r[1];
   wire rdy_pin_s = sy2_r[0];

   glitch_filter #(.RST_VAL(1'b0)) u_filt_p (
      .mclk(mclk),
      .rst(rst),
      .pin(pwm_in_p),
      .level(pwm_p_f)
   );

   glitch_filter #(.RST_VAL(1'b0)) u_filt_n (
      .mclk(mclk),
      .rst(rst),
      .pin(pwm_in_n),
      .level(pwm_n_f)
   );

   // Floating enable reads low, so the driver starts disabled
   glitch_filter #(.RST_VAL(1'b0)) u_filt_en (
      .mclk(mclk),
      .rst(rst),
      .pin(rst_en_in),
      .level(en_f)
   );

   // ************************************************
   // Fault sequence
   // ************************************************
   fault_state_e state_r;
   fault_state_e state_nxt;
   logic [7:0] hold_cnt_r;
   logic [7:0] hold_cnt_nxt;
   logic [7:0] mute_cnt_r;
   logic [7:0] low_cnt_r;
   logic en_d_r;
   logic gate_out_r;
   logic fault_oe_r;

   // Sense only trusted while the gate is driven high
   wire oc_hit = (state_r == ST_IDLE) & gate_out_r & oc_s;
   wire en_rise = en_f & ~en_d_r;
   wire mute_done = mute_cnt_r == 8'(`MUTE_CYC);
   wire rst_armed = low_cnt_r == 8'(`RSTFIL_CYC);
   wire clear_ok = (state_r == ST_LATCHED) & en_rise & rst_armed;

   always_comb begin
      state_nxt = state_r;
      hold_cnt_nxt = hold_cnt_r;
      unique case (state_r)
         ST_IDLE: begin
            if (oc_hit) begin
               state_nxt = ST_MID;
               hold_cnt_nxt = 8'h00;
            end
         end
         ST_MID: begin
            if (hold_cnt_r == 8'(HOLD_M1)) begin
               state_nxt = ST_SOFT;
            end else begin
               hold_cnt_nxt = hold_cnt_r + 8'h01;
            end
         end
         ST_SOFT: begin
            if (at_vee_s) begin
               state_nxt = ST_LATCHED;
            end
         end
         ST_LATCHED: begin
            if (clear_ok) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         hold_cnt_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         hold_cnt_r <= hold_cnt_nxt;
      end
   end

   // Mute runs from the flag; a low enable only counts once mute is over
   always_ff @(posedge mclk) begin
      if (rst) begin
         mute_cnt_r <= 8'h00;
         low_cnt_r <= 8'h00;
         en_d_r <= 1'b0;
      end else begin
         en_d_r <= en_f;
         if (oc_hit) begin
            mute_cnt_r <= 8'h00;
         end else if (state_r != ST_IDLE && !mute_done) begin
            mute_cnt_r <= mute_cnt_r + 8'h01;
         end
         if (en_f || state_r != ST_LATCHED || !mute_done) begin
            low_cnt_r <= 8'h00;
         end else if (!rst_armed) begin
            low_cnt_r <= low_cnt_r + 8'h01;
         end
      end
   end

   // ************************************************
   // Drive and flags
   // ************************************************
   wire supply_ok = ~uvlo_s;
   wire fault_free = (state_r == ST_IDLE) & ~oc_hit;
   wire drive_ok = supply_ok & en_f & fault_free & pwm_p_f & ~pwm_n_f;
   logic mid_r;
   logic soft_r;
   logic clamp_r;
   logic ready_oe_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         gate_out_r <= 1'b0;
         mid_r <= 1'b0;
         soft_r <= 1'b0;
         clamp_r <= 1'b0;
         fault_oe_r <= 1'b0;
         ready_oe_r <= 1'b1;
      end else begin
         gate_out_r <= drive_ok;
         mid_r <= state_nxt == ST_MID;
         soft_r <= state_nxt == ST_SOFT;
         // Held off while turning on so the clamp never fights the driver
         clamp_r <= below_s & ~drive_ok;
         if (oc_hit) begin
            fault_oe_r <= 1'b1;
         end else if (clear_ok) begin
            fault_oe_r <= 1'b0;
         end
         ready_oe_r <= uvlo_s;
      end
   end

   assign gate_out = gate_out_r;
   assign mid_turnoff_level = mid_r;
   assign soft_turnoff_current = soft_r;
   assign clamp_drive = clamp_r;
   assign oc_pulldown_o = 1'b0;
   assign oc_pulldown_oe = ~gate_out_r;
   assign fault_flag_n_o = 1'b0;
   assign fault_flag_n_oe = fault_oe_r;
   assign ready_o = 1'b0;
   assign ready_oe = ready_oe_r;

   // ************************************************
   // Sense encoder
   // ************************************************
   logic analog_pwm_out_en_r;
   logic [6:0] duty_w;

   sense_pwm u_sense (
      .mclk(mclk),
      .rst(rst),
      .enable(supply_ok & analog_pwm_out_en_r),
      .sense_mv(analog_sense_in),
      .pwm_out(analog_pwm_out),
      .high_cyc(duty_w)
   );

   // ************************************************
   // Register slave
   // ************************************************
   logic ack_r;
   logic [31:0] rdata_r;

   wire req = avs_read | avs_write;
   wire sel_ctrl = avs_address == `CTRL_OFS;
   wire sel_stat = avs_address == `STATUS_OFS;
   wire sel_duty = avs_address == `DUTY_OFS;
   wire [31:0] status_w = {24'h00_0000, rdy_pin_s, flt_pin_s, en_f, gate_out_r,
      uvlo_s, fault_oe_r, state_r};
   wire [31:0] rd_mux = sel_ctrl ? {31'h0000_0000, analog_pwm_out_en_r} :
      sel_stat ? status_w :
      sel_duty ? {25'h000_0000, duty_w} : 32'h0000_0000;
   wire ctrl_we = avs_write & ack_r & sel_ctrl & avs_byteenable[0];

   // One wait cycle per access; unmapped reads give zero
   assign avs_waitrequest = req & ~ack_r;
   assign avs_readdata = rdata_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         analog_pwm_out_en_r <= `CTRL_RST;
      end else begin
         ack_r <= req & ~ack_r;
         if (avs_read && !ack_r) begin
            rdata_r <= rd_mux;
         end
         if (ctrl_we) begin
            analog_pwm_out_en_r <= avs_writedata[`CTRL_ANALOG_PWM_OUT_EN_BIT];
         end
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   sequence s_enter_mid;
      state_r == ST_IDLE ##1 state_r == ST_MID;
   endsequence

   sequence s_mid_then_soft;
      ##HOLD_M1 state_r == ST_MID ##1 state_r == ST_SOFT;
   endsequence

   chk_clamp_low_gate: assert property (
      (below_s && !drive_ok) |=> clamp_drive)
      else $error("clamp not driven with gate below threshold");
   chk_oc_starts_off: assert property (
      oc_hit |=> (state_r == ST_MID) && fault_flag_n_oe && !gate_out)
      else $error("overcurrent did not start turn-off");
   chk_sense_release: assert property (
      !gate_out_r |-> oc_pulldown_oe ##1 (state_r != ST_MID || $past(state_r) != ST_IDLE))
      else $error("sense not held low with output low");
   chk_fault_holds_low: assert property (
      (state_r != ST_IDLE) |=> !gate_out)
      else $error("output high during fault");
   chk_two_level_off: assert property (
      s_enter_mid |-> s_mid_then_soft)
      else $error("mid level hold length wrong");
   chk_mute_ignore: assert property (
      (state_r == ST_LATCHED && !mute_done) |=> state_r == ST_LATCHED && fault_flag_n_oe)
      else $error("reset accepted during mute");
   chk_reset_clear: assert property (
      clear_ok |=> !fault_flag_n_oe && state_r == ST_IDLE)
      else $error("valid reset did not clear fault");
   chk_enable_off: assert property (
      !en_f |=> !gate_out && $stable(mid_turnoff_level) || state_r != ST_IDLE)
      else $error("disable did not turn off normally");
   chk_uvlo_outputs: assert property (
      uvlo_s ##1 uvlo_s |-> ready_oe && !gate_out ##1 !analog_pwm_out)
      else $error("undervoltage outputs wrong");
   chk_input_logic: assert property (
      (supply_ok && en_f && fault_free) |=> gate_out == $past(pwm_p_f && !pwm_n_f))
      else $error("drive output does not follow inputs");
   chk_fsm_order: assert property (
      (state_r == ST_LATCHED) |=> state_r inside {ST_LATCHED, ST_IDLE})
      else $error("fault state left latched illegally");
   chk_flag_latched: assert property (
      (fault_flag_n_oe && !clear_ok) |=> fault_flag_n_oe)
      else $error("fault flag released without valid reset");
   chk_uvlo_gate: assert property (
      uvlo_s |=> !gate_out)
      else $error("output high during undervoltage");
   chk_soft_until_rail: assert property (
      (state_r == ST_SOFT && !at_vee_s) |=> state_r == ST_SOFT && soft_turnoff_current)
      else $error("soft turn-off ended before the rail");
endmodule

// *** inc/drive_consts.svh ***
`ifndef DRIVE_CONSTS_SVH
`define DRIVE_CONSTS_SVH
// ************************************************
// Timing
// ************************************************
`define CLK_PERIOD_NS 20
`define GLITCH_NS 40
`define GLITCH_CYC ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MID_HOLD_NS 500
`define MID_HOLD_CYC ((`MID_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MUTE_NS 1000
`define MUTE_CYC ((`MUTE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RSTFIL_NS 800
`define RSTFIL_CYC ((`RSTFIL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ANALOG_PWM_OUT_FREQ_KHZ 400
`define ANALOG_PWM_OUT_PERIOD_CYC (1000000 / (`CLK_PERIOD_NS * `ANALOG_PWM_OUT_FREQ_KHZ))
// ************************************************
// Sense encoding
// ************************************************
`define SENSE_MIN_MV 600
`define SENSE_MAX_MV 4500
`define DUTY_MIN_PERMIL 100
`define DUTY_MAX_PERMIL 880
// ************************************************
// Register map and reset values
// ************************************************
`define CTRL_OFS 4'h0
`define STATUS_OFS 4'h4
`define DUTY_OFS 4'h8
`define CTRL_ANALOG_PWM_OUT_EN_BIT 0
`define CTRL_RST 1'h1
`define SYNC_RST 7'h62
`endif

// *** inc/drive_pkg.sv ***
package drive_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_MID = 2'h1,
      ST_SOFT = 2'h3,
      ST_LATCHED = 2'h2
   } fault_state_e;
endpackage

// *** src/glitch_filter.sv ***
`timescale 1ns/1ps
`include "drive_consts.svh"
module glitch_filter #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic pin,
   output logic level
);
   logic s1_r;
   logic s2_r;
   logic lvl_r;
   logic [2:0] cnt_r;

   // ************************************************
   // Sync then demand a stable new level
   // ************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         lvl_r <= RST_VAL;
         cnt_r <= 3'h0;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         if (s2_r == lvl_r) begin
            cnt_r <= 3'h0;
         end else if (cnt_r == 3'(`GLITCH_CYC - 1)) begin
            lvl_r <= s2_r;
            cnt_r <= 3'h0;
         end else begin
            cnt_r <= cnt_r + 3'h1;
         end
      end
   end

   assign level = lvl_r;

   chk_glitch_reject: assert property (@(posedge mclk) disable iff (rst)
      $changed(lvl_r) |-> ($past(s2_r) == lvl_r) && ($past(s2_r, 2) == lvl_r))
      else $error("level changed on a pulse shorter than the filter");
endmodule

// *** src/sense_pwm.sv ***
`timescale 1ns/1ps
`include "drive_consts.svh"
module sense_pwm (
   input wire logic mclk,
   input wire logic rst,
   input wire logic enable,
   input wire logic [12:0] sense_mv,
   output logic pwm_out,
   output logic [6:0] high_cyc
);
   localparam int PER_M1 = `ANALOG_PWM_OUT_PERIOD_CYC - 1;
   logic [6:0] cnt_r;
   logic [6:0] high_r;
   logic pwm_r;

   // Linear map, clamped so a floating input lands on the minimum duty
   function automatic logic [6:0] duty_of(input logic [12:0] mv);
      int v;
      int p;
      v = int'(mv);
      if (v > `SENSE_MAX_MV) v = `SENSE_MAX_MV;
      if (v < `SENSE_MIN_MV) v = `SENSE_MIN_MV;
      p = `DUTY_MIN_PERMIL + (`SENSE_MAX_MV - v) * (`DUTY_MAX_PERMIL - `DUTY_MIN_PERMIL)
         / (`SENSE_MAX_MV - `SENSE_MIN_MV);
      return 7'(p * `ANALOG_PWM_OUT_PERIOD_CYC / 1000);
   endfunction

   // ************************************************
   // Period counter, duty sampled once per period
   // ************************************************
   always_ff @(posedge mclk) begin
      if (rst || !enable) begin
         cnt_r <= 7'h00;
         high_r <= 7'h00;
         pwm_r <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == 7'(PER_M1)) ? 7'h00 : cnt_r + 7'h01;
         if (cnt_r == 7'(PER_M1) || high_r == 7'h00) begin
            high_r <= duty_of(sense_mv);
         end
         pwm_r <= cnt_r < high_r;
      end
   end

   assign pwm_out = pwm_r;
   assign high_cyc = high_r;

   chk_analog_pwm_out_period: assert property (@(posedge mclk) disable iff (rst)
      (enable && cnt_r == 7'h00) |-> ##PER_M1 (cnt_r == 7'(PER_M1) || !enable))
      else $error("sense pwm period wrong");
   chk_analog_pwm_out_duty: assert property (@(posedge mclk) disable iff (rst)
      ($fell(pwm_r) && $past(enable)) |-> ($past(cnt_r) == high_r))
      else $error("sense pwm fell at wrong count");
endmodule

// *** testbench/power_stage_model.sv ***
`timescale 1ns/1ps
// ****
// Far side: pull-ups, comparator pin, gate voltage
// ****
module power_stage_model #(
   parameter int FALL_CYC = 6
) (
   input wire logic mclk,
   input wire logic gate_out,
   input wire logic mid_turnoff_level,
   input wire logic oc_pulldown_o,
   input wire logic oc_pulldown_oe,
   input wire logic oc_raw,
   input wire logic fault_flag_n_o,
   input wire logic fault_flag_n_oe,
   input wire logic ready_o,
   input wire logic ready_oe,
   output logic overcurrent_sense,
   output logic fault_flag_n_i,
   output logic ready_i,
   output logic gate_below_clamp,
   output logic gate_at_neg_rail
);
   int fall_r = 0;
   // Slow discharge, so the soft stage really has to wait for the rail
   always @(posedge mclk) begin
      if (gate_out || mid_turnoff_level) begin
         fall_r <= 0;
      end else if (fall_r < FALL_CYC) begin
         fall_r <= fall_r + 1;
      end
   end
   assign gate_below_clamp = (fall_r >= FALL_CYC / 2);
   assign gate_at_neg_rail = (fall_r >= FALL_CYC);
   // Released open-drain lines float up through external pull-ups
   assign fault_flag_n_i = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
   assign ready_i = ready_oe ? ready_o : 1'b1;
   // Comparator sees the pin, which the internal pulldown may hold low
   assign overcurrent_sense = oc_pulldown_oe ? oc_pulldown_o : oc_raw;
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb
   import drive_pkg::*;
;
   logic mclk, rst, avs_read, avs_write, pwm_in_p, pwm_in_n, rst_en_in, vcc_uvlo, vdd_uvlo;
   logic [3:0] avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd, n;
   logic avs_waitrequest, overcurrent_sense, oc_raw, gate_below_clamp, gate_at_neg_rail;
   logic [12:0] analog_sense_in;
   logic gate_out, mid_turnoff_level, soft_turnoff_current, clamp_drive, oc_pulldown_o;
   logic oc_pulldown_oe, fault_flag_n_i, fault_flag_n_o, fault_flag_n_oe;
   logic ready_i, ready_o, ready_oe, analog_pwm_out;
   int fails = 0;
   int checked = 0;
   gate_drive_ctrl i_dut (
      .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_in_p(pwm_in_p),
      .pwm_in_n(pwm_in_n), .rst_en_in(rst_en_in), .vcc_uvlo(vcc_uvlo), .vdd_uvlo(vdd_uvlo),
      .overcurrent_sense(overcurrent_sense), .gate_below_clamp(gate_below_clamp),
      .gate_at_neg_rail(gate_at_neg_rail), .analog_sense_in(analog_sense_in),
      .gate_out(gate_out), .mid_turnoff_level(mid_turnoff_level),
      .soft_turnoff_current(soft_turnoff_current), .clamp_drive(clamp_drive),
      .oc_pulldown_o(oc_pulldown_o), .oc_pulldown_oe(oc_pulldown_oe),
      .fault_flag_n_i(fault_flag_n_i), .fault_flag_n_o(fault_flag_n_o),
      .fault_flag_n_oe(fault_flag_n_oe), .ready_i(ready_i), .ready_o(ready_o),
      .ready_oe(ready_oe), .analog_pwm_out(analog_pwm_out)
   );
   power_stage_model i_stage (
      .mclk(mclk), .gate_out(gate_out), .mid_turnoff_level(mid_turnoff_level),
      .oc_pulldown_o(oc_pulldown_o), .oc_pulldown_oe(oc_pulldown_oe), .oc_raw(oc_raw),
      .fault_flag_n_o(fault_flag_n_o), .fault_flag_n_oe(fault_flag_n_oe),
      .ready_o(ready_o), .ready_oe(ready_oe), .overcurrent_sense(overcurrent_sense),
      .fault_flag_n_i(fault_flag_n_i), .ready_i(ready_i),
      .gate_below_clamp(gate_below_clamp), .gate_at_neg_rail(gate_at_neg_rail)
   );
   // ****
   // Helpers
   // ****
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task close_out;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      close_out;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask
   // Whole Avalon transfer; waitrequest and data taken at the answering edge
   task bus(input logic wr, input logic [3:0] adr, input logic [3:0] be, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge mclk);
      avs_address <= adr;
      avs_byteenable <= be;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge mclk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 100);
      if (avs_waitrequest !== 1'b0) fails++;
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // High cycles over one full sense period of 125 cycles
   task count_hi;
      n = 32'h0000_0000;
      repeat (125) begin
         @(negedge mclk);
         n = n + {31'h0, analog_pwm_out};
      end
   endtask
   // ****
   // Tests
   // ****
   initial begin
      rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
      avs_byteenable = 4'hf; avs_writedata = 32'h0000_0000; pwm_in_p = 1'b0;
      pwm_in_n = 1'b0; rst_en_in = 1'b0; vcc_uvlo = 1'b0; vdd_uvlo = 1'b0;
      oc_raw = 1'b0; analog_sense_in = 13'h1388;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      cyc(8);
      check(ready_oe, 1'b0);
      check(ready_i, 1'b1);
      bus(1'b0, 4'h0, 4'hf, 32'h0000_0000);
      check(rd, 32'h0000_0001);
      bus(1'b0, 4'hc, 4'hf, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      @(posedge mclk) pwm_in_p <= 1'b1;
      cyc(10);
      check(gate_out, 1'b0);
      check(clamp_drive, 1'b1);
      @(posedge mclk) rst_en_in <= 1'b1;
      cyc(10);
      check(gate_out, 1'b1);
      check(clamp_drive, 1'b0);
      check(oc_pulldown_oe, 1'b0);
      @(posedge mclk) rst_en_in <= 1'b0;
      @(posedge mclk) rst_en_in <= 1'b1;
      @(posedge mclk) pwm_in_n <= 1'b1;
      @(posedge mclk) pwm_in_n <= 1'b0;
      cyc(8);
      check(gate_out, 1'b1);
      @(posedge mclk) pwm_in_n <= 1'b1;
      cyc(8);
      check(gate_out, 1'b0);
      check(oc_pulldown_oe, 1'b1);
      @(posedge mclk) oc_raw <= 1'b1;
      cyc(8);
      check(fault_flag_n_oe, 1'b0);
      @(posedge mclk) oc_raw <= 1'b0;
      pwm_in_n <= 1'b0;
      vdd_uvlo <= 1'b1;
      cyc(8);
      check(gate_out, 1'b0);
      check(ready_i, 1'b0);
      count_hi;
      check(n, 32'h0000_0000);
      @(posedge mclk) vdd_uvlo <= 1'b0;
      vcc_uvlo <= 1'b1;
      cyc(8);
      check(gate_out, 1'b0);
      check(ready_oe, 1'b1);
      @(posedge mclk) vcc_uvlo <= 1'b0;
      cyc(130);
      check(gate_out, 1'b1);
      count_hi;
      check(n, 32'h0000_000c);
      bus(1'b0, 4'h8, 4'hf, 32'h0000_0000);
      check(rd, 32'h0000_000c);
      @(posedge mclk) analog_sense_in <= 13'h0258;
      cyc(260);
      count_hi;
      check(n, 32'h0000_006e);
      @(posedge mclk) analog_sense_in <= 13'h1194;
      cyc(260);
      count_hi;
      check(n, 32'h0000_000c);
      bus(1'b1, 4'h0, 4'hf, 32'h0000_0000);
      bus(1'b1, 4'h0, 4'h0, 32'h0000_0001);
      bus(1'b0, 4'h0, 4'hf, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      count_hi;
      check(n, 32'h0000_0000);
      bus(1'b1, 4'h0, 4'hf, 32'h0000_0001);
      @(posedge mclk) rst_en_in <= 1'b0;
      cyc(8);
      check(gate_out, 1'b0);
      check(mid_turnoff_level, 1'b0);
      check(fault_flag_n_oe, 1'b0);
      @(posedge mclk) rst_en_in <= 1'b1;
      cyc(10);
      @(posedge mclk) oc_raw <= 1'b1;
      cyc(5);
      check(fault_flag_n_oe, 1'b1);
      check(mid_turnoff_level, 1'b1);
      check(gate_out, 1'b0);
      // Early reset attempt, mostly inside the mute window
      @(posedge mclk) oc_raw <= 1'b0;
      rst_en_in <= 1'b0;
      cyc(17);
      check(mid_turnoff_level, 1'b1);
      cyc(9);
      check(soft_turnoff_current, 1'b1);
      check(mid_turnoff_level, 1'b0);
      cyc(22);
      @(posedge mclk) rst_en_in <= 1'b1;
      cyc(12);
      check(fault_flag_n_oe, 1'b1);
      check(gate_out, 1'b0);
      check(soft_turnoff_current, 1'b0);
      bus(1'b0, 4'h4, 4'hf, 32'h0000_0000);
      check({30'h0, rd[1:0]}, {30'h0, ST_LATCHED});
      @(posedge mclk) rst_en_in <= 1'b0;
      cyc(50);
      check(fault_flag_n_i, 1'b0);
      @(posedge mclk) rst_en_in <= 1'b1;
      cyc(12);
      check(fault_flag_n_i, 1'b1);
      check(gate_out, 1'b1);
      close_out;
   end
endmodule
